// ### inc/gfcm_consts.svh
// Named constants for the glitch-free two-input clock switch.
// Assumes inclusion by bare name from the design files.
`ifndef GFCM_CONSTS_SVH
`define GFCM_CONSTS_SVH

// Bit positions of the first and second input in two-bit control vectors.
`define GFCM_FIRST 0
`define GFCM_SECOND 1

// Idle levels that the fixed-level variants force after configuration.
`define GFCM_IDLE_LOW 1'b0
`define GFCM_IDLE_HIGH 1'b1

// Value of every state flop while reset is asserted.
`define GFCM_STATE_RST '0

// Largest number of slow-clock rounds a select-driven switch may take.
`define GFCM_SW_LIMIT 3'h3
`define GFCM_ROUND_ONE 3'h1

// Control presets of the reduced variants.
`define GFCM_PAIR_FIRST 2'h1
`define GFCM_PAIR_BOTH 2'h3
`define GFCM_PAIR_NONE 2'h0

`endif

// ### inc/gfcm_pkg.sv
// Types shared by the clock switch and its edge tracker.
// Assumes gfcm_consts.svh is on the include path.
package gfcm_pkg;

	// Switch phases; RUN to WAIT_OLD to WAIT_NEW steps through adjacent codes, the return to RUN flips both bits.
	typedef enum logic [1:0] {
		GFCM_RUN = 2'h0,
		GFCM_WAIT_OLD = 2'h1,
		GFCM_WAIT_NEW = 2'h3,
		GFCM_PARK = 2'h2
	} gfcm_state_e;

	// Which clock input drives, or is about to drive, the output.
	typedef enum logic [1:0] {
		GFCM_SRC_NONE = 2'h0,
		GFCM_SRC_FIRST = 2'h1,
		GFCM_SRC_SECOND = 2'h2
	} gfcm_src_e;

	// Presets that derive the reduced variants from the full switch.
	typedef enum logic [3:0] {
		GFCM_V_FULL = 4'h0,
		GFCM_V_BUF = 4'h1,
		GFCM_V_GATE_LO = 4'h2,
		GFCM_V_GATE_HI = 4'h3,
		GFCM_V_MUX_FALL = 4'h4,
		GFCM_V_MUX_RISE = 4'h5,
		GFCM_V_MUX_SEL = 4'h6,
		GFCM_V_MUX_ASYNC = 4'h7,
		GFCM_V_MUX_SEL_EN = 4'h8
	} gfcm_variant_e;

	// Per-input control lines, bit 0 for the first input.
	typedef struct packed {
		logic [1:0] gate;
		logic [1:0] sel;
		logic [1:0] bypass;
	} gfcm_ctrl_s;

	// State of one edge tracker.
	typedef struct packed {
		logic prev;
	} gfcm_edge_s;

	// State of the switch.
	typedef struct packed {
		gfcm_state_e phase;
		gfcm_src_e cur;
		logic [1:0] sel_q;
		logic [1:0] gate_q;
		logic idle;
		logic cfg_done;
		logic out;
		logic busy;
		logic got_first;
		logic got_second;
		logic [2:0] rounds;
	} gfcm_state_s;

endpackage

// ### src/gfcm_edge_track.sv
// Edge tracker for one sampled clock input.
// Assumes the input is synchronous to clk, as all pins of this block are.
`timescale 1ns/100ps
`default_nettype none
`include "gfcm_consts.svh"

module gfcm_edge_track (
	input wire logic clk, // System clock.
	input wire logic rstn, // Asynchronous reset, active low.
	input wire logic clk_en, // Freezes the tracker while low.
	input wire logic level, // Sampled clock input.
	output logic rise, // Low-to-high seen this cycle.
	output logic fall // High-to-low seen this cycle.
);

	gfcm_pkg::gfcm_edge_s st;
	gfcm_pkg::gfcm_edge_s next_st;

	// --------------------------------------------------------------
	// Edge decode
	// --------------------------------------------------------------
	// Edges compare the live level with the last one, so the switch
	// acts in the same cycle that the edge is seen.
	assign rise = level & ~st.prev;
	assign fall = ~level & st.prev;

	// Capture the previous level only while enabled.
	always_comb begin
		next_st = st;
		if (clk_en) begin
			next_st.prev = level;
		end
	end

	// State register.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st <= `GFCM_STATE_RST;
		end else begin
			st <= next_st;
		end
	end

endmodule // gfcm_edge_track
`default_nettype wire

// ### src/gfcm_dual_input_clock_switch.sv
// Glitch-free two-input clock switch with presets for its variants.
// Assumes both clock inputs and all controls are synchronous to clk,
// and that the preselect straps are never both high.
//
// Function
// - Pass input whose gate and select pair both high.
// - No pair selected: output holds idle level.
// - Select change: old idle edge, then new.
// - Select-driven switching never glitches.
// - Gate-only switching skips waiting for old clock.
// - Bypass of current clock: switch away at once.
// - Idle level sets edge sense and held level.
// - Preselect straps choose starting clock; never both.
// - Plain buffer variant follows its clock.
// - Low-idle gate: low enable suppresses next pulse.
// - Low-idle gate: high pulse in progress completes.
// - High-idle gate mirrors low-idle gate.
// - Falling mux: old low, then new falling edge.
// - Rising mux: old high, then new rising edge.
// - Select-path mux: at most one extra old pulse.
// - Select-path switch within three slow-clock cycles.
// - Selects on idle edge, gates on active edge.
// - Enable off: output parked after current pulse.
`timescale 1ns/100ps
`default_nettype none
`include "gfcm_consts.svh"

module gfcm_dual_input_clock_switch (
	input wire logic clk, // System clock, 125 MHz.
	input wire logic rstn, // Asynchronous reset, active low.
	input wire logic clk_en, // Freezes all state while low.
	input wire logic first_clock_input, // First clock, sampled.
	input wire logic second_clock_input, // Second clock, sampled.
	input wire logic first_select, // Select of the first pair.
	input wire logic second_select, // Select of the second pair.
	input wire logic first_gate, // Gate of the first pair.
	input wire logic second_gate, // Gate of the second pair.
	input wire logic first_edge_bypass, // Leave first clock at once.
	input wire logic second_edge_bypass, // Leave second clock at once.
	input wire logic preselect_first, // Strap: start on first clock.
	input wire logic preselect_second, // Strap: start on second clock.
	input wire logic idle_level, // Strap: idle level, variants without a fixed one.
	input wire gfcm_pkg::gfcm_variant_e variant, // Strap: preset.
	input wire logic one_select, // Mux variants: high picks second.
	input wire logic one_gate, // Gated variants: enable.
	output logic clk_out, // Switched clock.
	output logic [1:0] active_src, // Input driving or next to drive.
	output logic switching // A change of input is in progress.
);

	gfcm_pkg::gfcm_state_s st;
	gfcm_pkg::gfcm_state_s next_st;
	gfcm_pkg::gfcm_ctrl_s ctrl;
	gfcm_pkg::gfcm_src_e tgt;
	logic idl;
	logic [1:0] clk_v;
	logic [1:0] rise_v;
	logic [1:0] fall_v;
	logic [1:0] idle_edge_v;
	logic [1:0] act_edge_v;
	logic [1:0] sel_eff;
	logic [1:0] gate_eff;
	logic byp;
	logic old_edge;
	logic new_edge;
	logic by_select;
	logic safe_leave;

	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------

	// Winner of the two pairs; both asserted keeps the old input.
	function automatic gfcm_pkg::gfcm_src_e pick_src(
		input logic [1:0] gate,
		input logic [1:0] sel,
		input gfcm_pkg::gfcm_src_e keep
	);
		logic w0;
		logic w1;
		w0 = gate[`GFCM_FIRST] & sel[`GFCM_FIRST];
		w1 = gate[`GFCM_SECOND] & sel[`GFCM_SECOND];
		if (w0 && w1) begin
			pick_src = keep;
		end else if (w0) begin
			pick_src = gfcm_pkg::GFCM_SRC_FIRST;
		end else if (w1) begin
			pick_src = gfcm_pkg::GFCM_SRC_SECOND;
		end else begin
			pick_src = gfcm_pkg::GFCM_SRC_NONE;
		end
	endfunction

	// Bit of a two-input vector that belongs to a source.
	function automatic logic src_bit(
		input gfcm_pkg::gfcm_src_e src,
		input logic [1:0] v
	);
		unique case (src)
			gfcm_pkg::GFCM_SRC_NONE: src_bit = 1'b0;
			gfcm_pkg::GFCM_SRC_FIRST: src_bit = v[`GFCM_FIRST];
			gfcm_pkg::GFCM_SRC_SECOND: src_bit = v[`GFCM_SECOND];
			default: src_bit = 1'b0;
		endcase
	endfunction

	// Presets that tie the unused control lines of each variant.
	function automatic gfcm_pkg::gfcm_ctrl_s map_variant(
		input gfcm_pkg::gfcm_variant_e v,
		input gfcm_pkg::gfcm_ctrl_s raw,
		input logic sel,
		input logic en
	);
		map_variant = raw;
		unique case (v)
			gfcm_pkg::GFCM_V_FULL: map_variant = raw;
			gfcm_pkg::GFCM_V_BUF: begin
				map_variant.gate = `GFCM_PAIR_FIRST;
				map_variant.sel = `GFCM_PAIR_FIRST;
				map_variant.bypass = `GFCM_PAIR_NONE;
			end
			gfcm_pkg::GFCM_V_GATE_LO, gfcm_pkg::GFCM_V_GATE_HI: begin
				map_variant.gate = {1'b0, en};
				map_variant.sel = `GFCM_PAIR_FIRST;
				map_variant.bypass = `GFCM_PAIR_NONE;
			end
			gfcm_pkg::GFCM_V_MUX_FALL, gfcm_pkg::GFCM_V_MUX_RISE,
			gfcm_pkg::GFCM_V_MUX_SEL: begin
				map_variant.gate = `GFCM_PAIR_BOTH;
				map_variant.sel = {sel, ~sel};
				map_variant.bypass = `GFCM_PAIR_NONE;
			end
			gfcm_pkg::GFCM_V_MUX_ASYNC: begin
				map_variant.gate = `GFCM_PAIR_BOTH;
				map_variant.sel = {sel, ~sel};
				map_variant.bypass = `GFCM_PAIR_BOTH;
			end
			gfcm_pkg::GFCM_V_MUX_SEL_EN: begin
				map_variant.gate = {en, en};
				map_variant.sel = {sel, ~sel};
				map_variant.bypass = `GFCM_PAIR_NONE;
			end
			default: map_variant = raw;
		endcase
	endfunction

	// Idle level of each variant; the full switch takes the strap.
	function automatic logic variant_idle(
		input gfcm_pkg::gfcm_variant_e v,
		input logic strap
	);
		unique case (v)
			gfcm_pkg::GFCM_V_GATE_HI,
			gfcm_pkg::GFCM_V_MUX_RISE: variant_idle = `GFCM_IDLE_HIGH;
			gfcm_pkg::GFCM_V_GATE_LO,
			gfcm_pkg::GFCM_V_MUX_FALL: variant_idle = `GFCM_IDLE_LOW;
			default: variant_idle = strap;
		endcase
	endfunction

	// --------------------------------------------------------------
	// Edge trackers
	// --------------------------------------------------------------
	assign clk_v = {second_clock_input, first_clock_input};

	gfcm_edge_track u_first_edge (
		.clk(clk),
		.rstn(rstn),
		.clk_en(clk_en),
		.level(first_clock_input),
		.rise(rise_v[`GFCM_FIRST]),
		.fall(fall_v[`GFCM_FIRST])
	);

	gfcm_edge_track u_second_edge (
		.clk(clk),
		.rstn(rstn),
		.clk_en(clk_en),
		.level(second_clock_input),
		.rise(rise_v[`GFCM_SECOND]),
		.fall(fall_v[`GFCM_SECOND])
	);

	// --------------------------------------------------------------
	// Control sampling
	// --------------------------------------------------------------
	// The idle edge is the one that enters the idle level: falling
	// for idle low, rising for idle high. Selects are taken on it and
	// gates on the opposite edge, so a gate dropped before an active
	// edge removes the whole following pulse instead of cutting it.
	// A bypassed current clock takes the selects live, which is what
	// lets a stopped clock be left at all.
	always_comb begin
		ctrl = map_variant(variant,
			{second_gate, first_gate, second_select, first_select,
			second_edge_bypass, first_edge_bypass},
			one_select, one_gate);
		idl = st.idle;
		idle_edge_v = idl ? rise_v : fall_v;
		act_edge_v = idl ? fall_v : rise_v;
		byp = src_bit(st.cur, ctrl.bypass);
		sel_eff = ((|idle_edge_v) || byp) ? ctrl.sel : st.sel_q;
		gate_eff = (|act_edge_v) ? ctrl.gate : st.gate_q;
		tgt = pick_src(gate_eff, sel_eff, st.cur);
		old_edge = src_bit(st.cur, idle_edge_v);
		new_edge = src_bit(tgt, idle_edge_v);
		by_select = ~src_bit(st.cur, sel_eff);
		// A gate taken at the other clock's edge must not cut a pulse of
		// the current one, so leaving waits for the output or the current clock to stand idle.
		safe_leave = (st.out == st.idle) ||
			(src_bit(st.cur, clk_v) == st.idle);
	end

	// --------------------------------------------------------------
	// Switch sequencer
	// --------------------------------------------------------------
	// The output follows the driving clock in RUN and WAIT_OLD and
	// sits at the idle level otherwise. WAIT_OLD ends on the idle
	// edge of the old clock and WAIT_NEW on that of the new one, so
	// each hand-over happens while both sides are at the idle level.
	always_comb begin
		next_st = st;
		if (clk_en && !st.cfg_done) begin
			// First enabled cycle after reset: catch the straps.
			next_st.cfg_done = 1'b1;
			next_st.idle = variant_idle(variant, idle_level);
			next_st.sel_q = ctrl.sel;
			next_st.gate_q = ctrl.gate;
			if (preselect_first) begin
				next_st.cur = gfcm_pkg::GFCM_SRC_FIRST;
				next_st.phase = gfcm_pkg::GFCM_RUN;
			end else if (preselect_second) begin
				next_st.cur = gfcm_pkg::GFCM_SRC_SECOND;
				next_st.phase = gfcm_pkg::GFCM_RUN;
			end else begin
				next_st.cur = gfcm_pkg::GFCM_SRC_NONE;
				next_st.phase = gfcm_pkg::GFCM_PARK;
			end
			next_st.out = variant_idle(variant, idle_level);
		end else if (clk_en) begin
			next_st.sel_q = sel_eff;
			next_st.gate_q = gate_eff;
			unique case (st.phase)
				gfcm_pkg::GFCM_RUN: begin
					if (tgt != st.cur) begin
						if (byp) begin
							next_st.cur = tgt;
							next_st.phase = (tgt == gfcm_pkg::GFCM_SRC_NONE) ?
								gfcm_pkg::GFCM_PARK : gfcm_pkg::GFCM_RUN;
						end else if (by_select) begin
							next_st.phase = gfcm_pkg::GFCM_WAIT_OLD;
						end else if (safe_leave) begin
							// Gate-driven: leave once no pulse is cut.
							next_st.cur = tgt;
							next_st.phase = (tgt == gfcm_pkg::GFCM_SRC_NONE) ?
								gfcm_pkg::GFCM_PARK :
								gfcm_pkg::GFCM_WAIT_NEW;
						end
					end
				end
				gfcm_pkg::GFCM_WAIT_OLD: begin
					if (tgt == st.cur) begin
						next_st.phase = gfcm_pkg::GFCM_RUN;
					end else if (byp || old_edge) begin
						next_st.cur = tgt;
						next_st.phase = (tgt == gfcm_pkg::GFCM_SRC_NONE) ?
							gfcm_pkg::GFCM_PARK :
							(byp ? gfcm_pkg::GFCM_RUN :
							gfcm_pkg::GFCM_WAIT_NEW);
					end
				end
				gfcm_pkg::GFCM_WAIT_NEW: begin
					if (tgt == gfcm_pkg::GFCM_SRC_NONE) begin
						next_st.cur = tgt;
						next_st.phase = gfcm_pkg::GFCM_PARK;
					end else if (tgt != st.cur) begin
						next_st.cur = tgt;
					end else if (new_edge) begin
						next_st.phase = gfcm_pkg::GFCM_RUN;
					end
				end
				gfcm_pkg::GFCM_PARK: begin
					if (tgt != gfcm_pkg::GFCM_SRC_NONE) begin
						next_st.cur = tgt;
						next_st.phase = gfcm_pkg::GFCM_WAIT_NEW;
					end
				end
			endcase
			// Outputs: live clock while it drives, idle otherwise.
			if (next_st.phase == gfcm_pkg::GFCM_RUN ||
				next_st.phase == gfcm_pkg::GFCM_WAIT_OLD) begin
				next_st.out = src_bit(next_st.cur, clk_v);
			end else begin
				next_st.out = st.idle;
			end
			next_st.busy = (next_st.phase == gfcm_pkg::GFCM_WAIT_OLD) ||
				(next_st.phase == gfcm_pkg::GFCM_WAIT_NEW);
			// Rounds of the slower clock spent on one switch request.
			if (!next_st.busy || sel_eff != st.sel_q ||
				gate_eff != st.gate_q) begin
				next_st.got_first = 1'b0;
				next_st.got_second = 1'b0;
				next_st.rounds = '0;
			end else if ((st.got_first || idle_edge_v[`GFCM_FIRST]) &&
				(st.got_second || idle_edge_v[`GFCM_SECOND])) begin
				next_st.got_first = 1'b0;
				next_st.got_second = 1'b0;
				next_st.rounds = st.rounds + `GFCM_ROUND_ONE;
			end else begin
				next_st.got_first = st.got_first | idle_edge_v[`GFCM_FIRST];
				next_st.got_second =
					st.got_second | idle_edge_v[`GFCM_SECOND];
			end
		end
	end

	// State register; reset parks the output low until straps load.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st <= `GFCM_STATE_RST;
		end else begin
			st <= next_st;
		end
	end

	assign clk_out = st.out;
	assign active_src = st.cur;
	assign switching = st.busy;

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	// A running first clock is echoed one cycle later.
	a_first_echo: assert property (@(posedge clk) disable iff (!rstn)
		($past(clk_en) && $past(st.cfg_done) &&
		st.phase == gfcm_pkg::GFCM_RUN &&
		st.cur == gfcm_pkg::GFCM_SRC_FIRST)
		|-> st.out == $past(first_clock_input))
		else $error("first clock not passed to output");

	// Away from the idle level only while a clock drives.
	a_idle_only: assert property (@(posedge clk) disable iff (!rstn)
		(st.cfg_done && st.out != st.idle)
		|-> (st.phase == gfcm_pkg::GFCM_RUN ||
		st.phase == gfcm_pkg::GFCM_WAIT_OLD))
		else $error("output left idle level with no clock selected");

	// The new clock takes over only on its own idle edge.
	a_new_edge: assert property (@(posedge clk) disable iff (!rstn)
		($past(clk_en) && $past(st.phase) == gfcm_pkg::GFCM_WAIT_NEW &&
		st.phase == gfcm_pkg::GFCM_RUN)
		|-> $past(new_edge) && st.out == st.idle)
		else $error("new clock started off its idle edge");

	// The old clock is left only at its idle edge or when bypassed.
	a_old_edge: assert property (@(posedge clk) disable iff (!rstn)
		($past(clk_en) && $past(st.phase) == gfcm_pkg::GFCM_WAIT_OLD &&
		st.phase == gfcm_pkg::GFCM_WAIT_NEW)
		|-> $past(old_edge) && !$past(byp))
		else $error("old clock left before its idle edge");

	// Gate-only change goes straight to waiting for the new clock.
	a_gate_fast: assert property (@(posedge clk) disable iff (!rstn)
		(clk_en && st.cfg_done && st.phase == gfcm_pkg::GFCM_RUN &&
		tgt != st.cur && tgt != gfcm_pkg::GFCM_SRC_NONE &&
		!byp && !by_select && safe_leave)
		|=> st.phase == gfcm_pkg::GFCM_WAIT_NEW && st.out == st.idle)
		else $error("gate change waited for old clock");

	// A bypassed clock is left in the very next cycle.
	a_bypass_now: assert property (@(posedge clk) disable iff (!rstn)
		(clk_en && st.cfg_done && st.phase == gfcm_pkg::GFCM_RUN &&
		byp && tgt != st.cur && tgt != gfcm_pkg::GFCM_SRC_NONE)
		|=> st.phase == gfcm_pkg::GFCM_RUN && st.cur == $past(tgt))
		else $error("bypassed clock not left at once");

	// After reset the output starts at the idle level on the strap.
	a_strap_load: assert property (@(posedge clk) disable iff (!rstn)
		$rose(st.cfg_done)
		|-> st.out == st.idle &&
		(preselect_first == (st.cur == gfcm_pkg::GFCM_SRC_FIRST)))
		else $error("reset did not load idle level and preselect");

	// Low-idle gate: a low enable at a rising edge kills the pulse.
	a_gate_kill: assert property (@(posedge clk) disable iff (!rstn)
		(clk_en && st.cfg_done && variant == gfcm_pkg::GFCM_V_GATE_LO &&
		rise_v[`GFCM_FIRST] && !one_gate)
		|=> !st.out [*2])
		else $error("gated pulse passed while disabled");

	// Gates change their sampled value only on an active edge.
	a_gate_sample: assert property (@(posedge clk) disable iff (!rstn)
		(clk_en && st.cfg_done && !(|act_edge_v)) |=> $stable(st.gate_q))
		else $error("gate sampled off the active edge");

	// A switch ends within the allowed rounds of the slower clock.
	a_switch_bound: assert property (@(posedge clk) disable iff (!rstn)
		st.busy |-> st.rounds < `GFCM_SW_LIMIT)
		else $error("switch took too many slow-clock cycles");

endmodule // gfcm_dual_input_clock_switch
`default_nettype wire

// ### verification/gfcm_clk_src.sv
// Partner model: two sampled clock sources for the clock switch.
// Assumes the bench clock paces it and the bench starts and stops it.
`timescale 1ns/100ps
`default_nettype none

module gfcm_clk_src (
	input wire logic clk, // Bench clock.
	input wire logic rstn, // Reset, active low.
	input wire logic run1, // First source toggles while high.
	input wire logic run2, // Second source toggles while high.
	output logic c1, // First clock, half period 3 cycles.
	output logic c2 // Second clock, half period 5 cycles.
);
	logic [2:0] n1;
	logic [2:0] n2;

	// Coprime half periods make the two sources drift against each other.
	// A stopped source holds its level, as a dead oscillator would.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			c1 <= 1'b0;
			c2 <= 1'b0;
			n1 <= 3'h0;
			n2 <= 3'h0;
		end else begin
			n1 <= (run1 && n1 != 3'h2) ? n1 + 3'h1 : 3'h0;
			n2 <= (run2 && n2 != 3'h4) ? n2 + 3'h1 : 3'h0;
			if (run1 && n1 == 3'h2)
				c1 <= ~c1;
			if (run2 && n2 == 3'h4)
				c2 <= ~c2;
		end
	end
endmodule // gfcm_clk_src

`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for the glitch-free clock switch and its presets.
// Assumes the design package is compiled first and one bench clock.
`timescale 1ns/100ps
`default_nettype none

module tb;
	logic clk, rstn, fs, ss, fg, sg, fb, sb, pf, ps, idl, osel, ogate;
	logic run1, run2, c1, c2, clk_out, switching, glitch_on, last, ce;
	logic [1:0] active_src;
	gfcm_pkg::gfcm_variant_e vsel;
	int n_fail, n_tests, run;

	gfcm_clk_src src (.clk(clk), .rstn(rstn), .run1(run1), .run2(run2),
		.c1(c1), .c2(c2));

	gfcm_dual_input_clock_switch dut (.clk(clk), .rstn(rstn),
		.clk_en(ce), .first_clock_input(c1), .second_clock_input(c2),
		.first_select(fs), .second_select(ss), .first_gate(fg),
		.second_gate(sg), .first_edge_bypass(fb),
		.second_edge_bypass(sb), .preselect_first(pf),
		.preselect_second(ps), .idle_level(idl), .variant(vsel),
		.one_select(osel), .one_gate(ogate), .clk_out(clk_out),
		.active_src(active_src), .switching(switching));

	// Bench clock, 125 MHz.
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic close_out();
		if (n_fail == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// A level shorter than the fastest half period is a glitch.
	always @(negedge clk) begin
		if (!glitch_on) begin
			run = 99;
			last = clk_out;
		end else if (clk_out !== last) begin
			if (run < 3)
				chk(run[3:0], 4'h3);
			run = 1;
			last = clk_out;
		end else
			run++;
	end

	// The output repeats the chosen source one cycle late.
	task automatic follow(input logic second, input int n);
		logic p;
		@(negedge clk);
		p = second ? c2 : c1;
		repeat (n) begin
			@(negedge clk);
			chk(clk_out, p);
			p = second ? c2 : c1;
		end
	endtask

	task automatic hold(input logic lvl, input int n);
		repeat (n) begin
			@(negedge clk);
			chk(clk_out, lvl);
		end
	endtask

	// While waiting on the new source the output must sit idle.
	task automatic wait_src(input logic [1:0] exp, input int bound,
		input logic lvl);
		int i;
		for (i = 0; i < bound; i++) begin
			@(negedge clk);
			if (switching === 1'b1 && active_src === exp)
				chk(clk_out, lvl);
			if (switching === 1'b0 && active_src === exp)
				break;
		end
		if (i == bound) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, active_src, exp);
			close_out();
		end
	endtask

	// Straps are never both high; the bench keeps that.
	task automatic do_reset(input gfcm_pkg::gfcm_variant_e v,
		input logic i, input logic p1, input logic p2);
		glitch_on = 1'b0;
		@(posedge clk);
		rstn <= 1'b0;
		vsel <= v;
		idl <= i;
		pf <= p1;
		ps <= p2;
		repeat (16) @(posedge clk);
		chk({clk_out, switching, active_src}, 4'h0);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
	endtask

	task automatic s_full_low();
		@(posedge clk);
		fs <= 1'b1;
		fg <= 1'b1;
		do_reset(gfcm_pkg::GFCM_V_FULL, 1'b0, 1'b1, 1'b0);
		chk(active_src, 4'h1);
		follow(1'b0, 20);
		glitch_on = 1'b1;
		@(posedge clk);
		fs <= 1'b0;
		ss <= 1'b1;
		sg <= 1'b1;
		wait_src(2'h2, 40, 1'b0);
		@(posedge clk);
		fs <= 1'b1;
		follow(1'b1, 30);
		@(posedge clk);
		fs <= 1'b0;
		ss <= 1'b0;
		repeat (24) @(posedge clk);
		hold(1'b0, 30);
	endtask

	task automatic s_gate_only();
		int k;
		@(posedge clk);
		fs <= 1'b1;
		ss <= 1'b1;
		sg <= 1'b0;
		wait_src(2'h1, 40, 1'b0);
		// Stop the first clock just after a fall, so it dies at idle low.
		for (k = 0; k < 8; k++) begin
			@(negedge clk);
			if (c1 === 1'b1)
				break;
		end
		for (k = 0; k < 8; k++) begin
			@(negedge clk);
			if (c1 === 1'b0)
				break;
		end
		@(posedge clk);
		run1 <= 1'b0;
		fg <= 1'b0;
		sg <= 1'b1;
		wait_src(2'h2, 30, 1'b0);
		follow(1'b1, 20);
		@(posedge clk);
		run1 <= 1'b1;
	endtask

	task automatic s_bypass();
		glitch_on = 1'b0;
		@(posedge clk);
		sb <= 1'b1;
		run2 <= 1'b0;
		fg <= 1'b1;
		repeat (8) @(posedge clk);
		chk(active_src, 4'h2);
		ss <= 1'b0;
		wait_src(2'h1, 4, 1'b0);
		follow(1'b0, 20);
		@(posedge clk);
		sb <= 1'b0;
		run2 <= 1'b1;
	endtask

	// A low clock enable freezes the output wherever it stands.
	task automatic s_freeze();
		logic v;
		@(posedge clk);
		ce <= 1'b0;
		@(negedge clk);
		v = clk_out;
		hold(v, 10);
		@(posedge clk);
		ce <= 1'b1;
	endtask

	task automatic s_idle_high();
		@(posedge clk);
		fs <= 1'b0;
		fg <= 1'b0;
		ss <= 1'b1;
		sg <= 1'b1;
		do_reset(gfcm_pkg::GFCM_V_FULL, 1'b1, 1'b0, 1'b1);
		chk(active_src, 4'h2);
		follow(1'b1, 20);
		glitch_on = 1'b1;
		@(posedge clk);
		fs <= 1'b1;
		fg <= 1'b1;
		ss <= 1'b0;
		wait_src(2'h1, 40, 1'b1);
		follow(1'b0, 20);
		@(posedge clk);
		fs <= 1'b0;
		repeat (24) @(posedge clk);
		hold(1'b1, 30);
	endtask

	// The plain buffer has no select, so it must stay on the first clock.
	task automatic mux_run(input gfcm_pkg::gfcm_variant_e v,
		input logic lvl, input int bound);
		logic tosec;
		tosec = (v != gfcm_pkg::GFCM_V_BUF);
		@(posedge clk);
		osel <= 1'b0;
		do_reset(v, lvl, 1'b1, 1'b0);
		follow(1'b0, 12);
		glitch_on = (v != gfcm_pkg::GFCM_V_MUX_ASYNC);
		@(posedge clk);
		osel <= 1'b1;
		wait_src({tosec, ~tosec}, bound, lvl);
		follow(tosec, 12);
	endtask

	task automatic gate_run(input gfcm_pkg::gfcm_variant_e v,
		input logic lvl);
		@(posedge clk);
		osel <= 1'b0;
		ogate <= 1'b1;
		do_reset(v, lvl, 1'b1, 1'b0);
		follow(1'b0, 12);
		glitch_on = 1'b1;
		@(posedge clk);
		ogate <= 1'b0;
		repeat (12) @(posedge clk);
		hold(lvl, 20);
	endtask

	// Main sequence; every input starts at a defined level.
	initial begin
		n_fail = 0;
		n_tests = 0;
		{rstn, fs, ss, fg, sg, fb, sb, pf, ps, idl, osel, ogate} = '0;
		{run1, run2, glitch_on} = 3'b110;
		ce = 1'b1;
		vsel = gfcm_pkg::GFCM_V_FULL;
		s_full_low();
		s_gate_only();
		s_bypass();
		s_freeze();
		s_idle_high();
		mux_run(gfcm_pkg::GFCM_V_BUF, 1'b0, 2);
		gate_run(gfcm_pkg::GFCM_V_GATE_LO, 1'b0);
		gate_run(gfcm_pkg::GFCM_V_GATE_HI, 1'b1);
		mux_run(gfcm_pkg::GFCM_V_MUX_FALL, 1'b0, 40);
		mux_run(gfcm_pkg::GFCM_V_MUX_RISE, 1'b1, 40);
		mux_run(gfcm_pkg::GFCM_V_MUX_SEL, 1'b0, 32);
		mux_run(gfcm_pkg::GFCM_V_MUX_ASYNC, 1'b0, 4);
		gate_run(gfcm_pkg::GFCM_V_MUX_SEL_EN, 1'b0);
		close_out();
	end
endmodule // tb

`default_nettype wire
